/* File: rtl/gfcs_consts.svh */
// Offsets, field positions, reset values and switch timing counts of the clock switch
`ifndef GFCS_CONSTS_SVH
`define GFCS_CONSTS_SVH

// ==========================================================
// Register map (byte addresses)
`define GFCS_CTRL_OFS 12'h000
`define GFCS_STAT_OFS 12'h004

// ==========================================================
// Status field positions
`define GFCS_STAT_STARTUP_BIT 0
`define GFCS_STAT_INT_STABLE_BIT 1
`define GFCS_STAT_SECONDARY_BIT 2
`define GFCS_STAT_BUSY_BIT 3
`define GFCS_STAT_ACTIVE_LSB 4

// ==========================================================
// Reset values and postscaler select ends
`define GFCS_FREQ_RESET 3'h4
`define GFCS_FREQ_FULL 3'h7
`define GFCS_FREQ_LOWEST 3'h0
`define GFCS_CSS_RESET 2'h0

// ==========================================================
// Switch pause: outgoing periods, incoming falling edges
`define GFCS_OLD_CYCLES 2'h2
`define GFCS_NEW_CYCLES 2'h3

// ==========================================================
// Bus answers
`define GFCS_RESP_OKAY 2'h0
`define GFCS_RESP_SLVERR 2'h2

`endif

/* File: rtl/gfcs_pkg.sv */
// Types shared by the clock switch modules
package gfcs_pkg;

  typedef enum logic [1:0] {
    SRC_PRIMARY = 2'h0,
    SRC_SECONDARY = 2'h1,
    SRC_INTERNAL = 2'h2
  } gfcs_src_type;

  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_WAIT = 4'h2,
    ST_OLD = 4'h4,
    ST_NEW = 4'h8
  } gfcs_state_type;

  // Software control word, bit 0 at the bottom
  typedef struct packed {
    logic fail_safe_enable;
    logic watchdog_enable;
    logic idle_on_sleep_enable;
    logic [1:0] clock_source_select;
    logic low_freq_source_select;
    logic [2:0] internal_osc_freq_select;
  } gfcs_ctrl_type;

  // Asynchronous pin inputs, sampled together
  typedef struct packed {
    logic primary_clk;
    logic secondary_clk;
    logic fast_clk;
    logic slow_clk;
    logic primary_ready;
    logic secondary_ready;
    logic fast_ready;
  } gfcs_pins_type;

endpackage

/* File: rtl/gfcs_postscaler.sv */
// Postscaler of the fast internal oscillator: divide by 1 to 256
`include "gfcs_consts.svh"

module gfcs_postscaler (
  input logic aclk,
  input logic aresetn,
  input logic fast_lvl,
  input logic [2:0] freq_sel,
  output logic out_lvl
);

  logic fast_q;
  logic [7:0] div_cnt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_q <= 1'b0;
      div_cnt <= 8'h00;
    end else begin
      fast_q <= fast_lvl;
      if (fast_lvl && !fast_q) begin
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end

  // Counter bit k toggles at fast/2^(k+1); lowest select takes bit 7
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_lvl <= 1'b0;
    end else if (freq_sel == `GFCS_FREQ_FULL) begin
      out_lvl <= fast_lvl;
    end else if (freq_sel == `GFCS_FREQ_LOWEST) begin
      out_lvl <= div_cnt[7];
    end else begin
      out_lvl <= div_cnt[3'h6 - freq_sel];
    end
  end

endmodule

/* File: rtl/gfcs_sync.sv */
// Three-stage pin synchroniser; output moves when stages two and three agree
module gfcs_sync #(
  parameter int WIDTH = 7
) (
  input logic aclk,
  input logic aresetn,
  input logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      pin_out <= '0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          pin_out[i] <= stage3[i];
        end
      end
    end
  end

endmodule

/* File: rtl/gfcs_top.sv */
// Glitch-free system clock switch with AXI4-Lite control and status
`include "gfcs_consts.svh"

module gfcs_top
  import gfcs_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  input logic awvalid,
  output logic awready,
  input logic [31:0] awaddr,
  input logic wvalid,
  output logic wready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  output logic bvalid,
  input logic bready,
  output logic [1:0] bresp,
  input logic arvalid,
  output logic arready,
  input logic [31:0] araddr,
  output logic rvalid,
  input logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input logic primary_osc_clk,
  input logic secondary_osc_clk,
  input logic fast_internal_osc,
  input logic slow_rc_osc,
  input logic primary_osc_ready,
  input logic secondary_osc_ready,
  input logic fast_osc_ready,
  output logic core_clk,
  output logic primary_osc_enable,
  output logic fast_osc_enable,
  output logic slow_rc_enable,
  output logic startup_timer_done_flag,
  output logic internal_osc_stable_flag,
  output logic secondary_clock_active_flag,
  output logic idle_on_sleep_enable
);

  // ==========================================================
  // Helpers
  function automatic gfcs_src_type css_to_src(input logic [1:0] css);
    if (css[1]) begin
      return SRC_INTERNAL;
    end else if (css[0]) begin
      return SRC_SECONDARY;
    end else begin
      return SRC_PRIMARY;
    end
  endfunction

  function automatic logic src_level(input gfcs_src_type src, input gfcs_pins_type p, input logic int_lvl);
    case (src)
      SRC_PRIMARY: return p.primary_clk;
      SRC_SECONDARY: return p.secondary_clk;
      default: return int_lvl;
    endcase
  endfunction

  function automatic logic addr_hit(input logic [31:0] addr, input logic [11:0] ofs);
    return (addr[11:0] == ofs) && (addr[31:12] == 20'h00000);
  endfunction

  // ==========================================================
  // Pin sampling and internal multiplexer
  gfcs_pins_type pins_raw;
  gfcs_pins_type pins;
  gfcs_ctrl_type ctrl;
  logic int_en;
  logic int_rc;
  logic ps_lvl;
  logic int_lvl;

  assign pins_raw = '{primary_clk: primary_osc_clk, secondary_clk: secondary_osc_clk,
                      fast_clk: fast_internal_osc, slow_clk: slow_rc_osc,
                      primary_ready: primary_osc_ready, secondary_ready: secondary_osc_ready,
                      fast_ready: fast_osc_ready};

  gfcs_sync #(
    .WIDTH($bits(gfcs_pins_type))
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(pins_raw),
    .pin_out(pins)
  );

  gfcs_postscaler u_postscaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .fast_lvl(pins.fast_clk),
    .freq_sel(ctrl.internal_osc_freq_select),
    .out_lvl(ps_lvl)
  );

  assign int_en = (ctrl.internal_osc_freq_select != `GFCS_FREQ_LOWEST) || ctrl.low_freq_source_select;
  assign int_rc = !int_en;
  assign int_lvl = int_rc ? pins.slow_clk : ps_lvl;

  // ==========================================================
  // AXI4-Lite slave
  logic aw_have;
  logic w_have;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_do;

  assign wr_do = aw_have && w_have && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 32'h00000000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `GFCS_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_addr <= awaddr;
        aw_have <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
        w_have <= 1'b1;
        wready <= 1'b0;
      end
      if (wr_do) begin
        bvalid <= 1'b1;
        if (addr_hit(aw_addr, `GFCS_CTRL_OFS) || addr_hit(aw_addr, `GFCS_STAT_OFS)) begin
          bresp <= `GFCS_RESP_OKAY;
        end else begin
          bresp <= `GFCS_RESP_SLVERR;
        end
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_have <= 1'b0;
        w_have <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Only software alters the control word; the switch never writes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= '{internal_osc_freq_select: `GFCS_FREQ_RESET, clock_source_select: `GFCS_CSS_RESET,
                default: 1'b0};
    end else if (wr_do && addr_hit(aw_addr, `GFCS_CTRL_OFS)) begin
      if (w_strb[0]) begin
        ctrl[7:0] <= w_data[7:0];
      end
      if (w_strb[1]) begin
        ctrl[8] <= w_data[8];
      end
    end
  end

  // ==========================================================
  // Switch state machine
  gfcs_state_type state;
  gfcs_src_type active;
  gfcs_src_type pend;
  gfcs_src_type target;
  logic hold;
  logic [1:0] cnt;
  logic cur_lvl;
  logic new_lvl;
  logic cur_q;
  logic new_q;
  logic cur_fall;
  logic new_fall;
  logic tgt_ready;

  assign target = css_to_src(ctrl.clock_source_select);
  assign cur_lvl = src_level(active, pins, int_lvl);
  assign new_lvl = src_level(pend, pins, int_lvl);
  assign cur_fall = cur_q && !cur_lvl;
  assign new_fall = new_q && !new_lvl;

  always_comb begin
    case (target)
      SRC_PRIMARY: tgt_ready = pins.primary_ready;
      SRC_SECONDARY: tgt_ready = pins.secondary_ready;
      default: tgt_ready = int_rc || pins.fast_ready;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_q <= 1'b0;
      new_q <= 1'b0;
    end else begin
      cur_q <= cur_lvl;
      new_q <= new_lvl;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_RUN;
      active <= SRC_PRIMARY;
      pend <= SRC_PRIMARY;
      hold <= 1'b0;
      cnt <= 2'h0;
    end else begin
      case (state)
        ST_RUN: begin
          if (target != active) begin
            pend <= target;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Old source keeps the core running meanwhile
          pend <= target;
          if (target == active) begin
            state <= ST_RUN;
          end else if (tgt_ready) begin
            state <= ST_OLD;
            cnt <= 2'h0;
          end
        end
        ST_OLD: begin
          // Freeze low on a falling edge, then let two old periods pass
          if (cur_fall) begin
            if (!hold) begin
              hold <= 1'b1;
            end else if (cnt == `GFCS_OLD_CYCLES - 2'h1) begin
              cnt <= 2'h0;
              state <= ST_NEW;
            end else begin
              cnt <= cnt + 2'h1;
            end
          end
        end
        ST_NEW: begin
          // Third incoming fall: release while new source is low
          if (new_fall) begin
            if (cnt == `GFCS_NEW_CYCLES - 2'h1) begin
              cnt <= 2'h0;
              active <= pend;
              hold <= 1'b0;
              state <= ST_RUN;
            end else begin
              cnt <= cnt + 2'h1;
            end
          end
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_clk <= 1'b0;
    end else begin
      core_clk <= hold ? 1'b0 : cur_lvl;
    end
  end

  // ==========================================================
  // Source flags and oscillator enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      startup_timer_done_flag <= 1'b0;
      internal_osc_stable_flag <= 1'b0;
      secondary_clock_active_flag <= 1'b0;
    end else begin
      startup_timer_done_flag <= (active == SRC_PRIMARY) && pins.primary_ready;
      internal_osc_stable_flag <= (active == SRC_INTERNAL) && int_en && pins.fast_ready;
      secondary_clock_active_flag <= (active == SRC_SECONDARY);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      primary_osc_enable <= 1'b1;
      fast_osc_enable <= 1'b0;
      slow_rc_enable <= 1'b0;
      idle_on_sleep_enable <= 1'b0;
    end else begin
      primary_osc_enable <= (active == SRC_PRIMARY) || (target == SRC_PRIMARY);
      fast_osc_enable <= int_en;
      slow_rc_enable <= ctrl.watchdog_enable || ctrl.fail_safe_enable ||
                        (int_rc && ((active == SRC_INTERNAL) || (target == SRC_INTERNAL)));
      idle_on_sleep_enable <= ctrl.idle_on_sleep_enable;
    end
  end

  // ==========================================================
  // Register read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `GFCS_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= `GFCS_RESP_OKAY;
      if (addr_hit(araddr, `GFCS_CTRL_OFS)) begin
        rdata <= {23'h000000, ctrl};
      end else if (addr_hit(araddr, `GFCS_STAT_OFS)) begin
        rdata <= {26'h0000000, active, state != ST_RUN, secondary_clock_active_flag,
                  internal_osc_stable_flag, startup_timer_done_flag};
      end else begin
        rdata <= 32'h00000000;
        rresp <= `GFCS_RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ==========================================================
  // Checks
  sequence pause_old_s;
    (state == ST_OLD) && hold && cur_fall && (cnt == 2'h1);
  endsequence

  sequence pause_new_s;
    (state == ST_NEW) && new_fall && (cnt == 2'h2);
  endsequence

  flags_exclusive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $onehot0({startup_timer_done_flag, internal_osc_stable_flag, secondary_clock_active_flag}))
    else $error("more than one source flag set");

  int_off_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (int_rc && $past(int_rc)) |=> (!internal_osc_stable_flag && !fast_osc_enable))
    else $error("internal oscillator live while deselected");

  rc_kept_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl.watchdog_enable || ctrl.fail_safe_enable) |=> slow_rc_enable)
    else $error("slow rc stopped while watchdog or monitor on");

  wait_ready_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ((state == ST_WAIT) && !tgt_ready && (target != active)) |=> (state == ST_WAIT) && $stable(active))
    else $error("switch started before source ready");

  stall_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (hold && $past(hold)) |-> !core_clk)
    else $error("core clock moved during pause");

  old_to_new_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pause_old_s |=> (state == ST_NEW) && (cnt == 2'h0) && !core_clk)
    else $error("outgoing pause count wrong");

  switch_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pause_new_s and (pend == SRC_PRIMARY) && pins.primary_ready) |=> (active == SRC_PRIMARY) ##1
    (startup_timer_done_flag && !internal_osc_stable_flag))
    else $error("primary switch completion flags wrong");

  keep_clock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ((state == ST_WAIT) && !hold) |=> (core_clk == $past(cur_lvl)))
    else $error("core clock stopped while source starts");

  ctrl_steady_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ((state != ST_RUN) && !wr_do) |=> $stable(ctrl))
    else $error("switch altered control bits");

  reset_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> (ctrl.clock_source_select == 2'h0) && (ctrl.internal_osc_freq_select == 3'h4))
    else $error("reset values of select bits wrong");

endmodule

/* File: tb/gfcs_osc_model.sv */
// Behavioural oscillators, their readiness indications and the secondary source
module gfcs_osc_model (
  input wire logic aclk,
  input wire logic primary_osc_enable,
  input wire logic fast_osc_enable,
  input wire logic slow_rc_enable,
  input wire logic pri_stall,
  input wire logic sec_on,
  input int fast_delay,
  output logic primary_osc_clk,
  output logic secondary_osc_clk,
  output logic fast_internal_osc,
  output logic slow_rc_osc,
  output logic primary_osc_ready,
  output logic secondary_osc_ready,
  output logic fast_osc_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  int ph = 0;
  int pri_cnt = 0;
  int fast_cnt = 0;

  initial begin
    primary_osc_clk = 0;
    secondary_osc_clk = 0;
    fast_internal_osc = 0;
    slow_rc_osc = 0;
  end

  // ==========================================
  // Source clocks stand still while disabled
  always @(posedge aclk) begin
    ph <= ph + 1;
    pri_cnt <= primary_osc_enable ? pri_cnt + 1 : 0;
    fast_cnt <= fast_osc_enable ? fast_cnt + 1 : 0;
    if (primary_osc_enable && ph % 8 == 7) primary_osc_clk <= ~primary_osc_clk;
    if (fast_osc_enable && ph % 6 == 5) fast_internal_osc <= ~fast_internal_osc;
    if (slow_rc_enable && ph % 20 == 19) slow_rc_osc <= ~slow_rc_osc;
    if (sec_on && ph % 10 == 9) secondary_osc_clk <= ~secondary_osc_clk;
  end

  // ==========================================
  // Primary and fast readiness after a start-up interval; secondary ready as soon as it is on
  assign primary_osc_ready = primary_osc_enable && !pri_stall && pri_cnt > 40;
  assign fast_osc_ready = fast_osc_enable && fast_cnt > fast_delay;
  assign secondary_osc_ready = sec_on;
endmodule

/* File: tb/gfcs_top_tb.sv */
// Self-checking bench of the clock switch
`include "gfcs_consts.svh"

module gfcs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0;
  logic aresetn = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic primary_osc_clk, secondary_osc_clk, fast_internal_osc, slow_rc_osc;
  logic primary_osc_ready, secondary_osc_ready, fast_osc_ready;
  logic core_clk, primary_osc_enable, fast_osc_enable, slow_rc_enable, idle_on_sleep_enable;
  logic startup_timer_done_flag, internal_osc_stable_flag, secondary_clock_active_flag;
  logic pri_stall = 0, sec_on = 0, last_clk = 0;
  int fast_delay = 30;
  int num_errors = 0, checks_done = 0, cyc = 0;
  int run_len = 0, max_phase = 0, min_phase = 1000;
  bit seen_edge = 0;

  gfcs_top gfcs_top_inst (.*);
  gfcs_osc_model gfcs_osc_model_inst (.*);

  initial begin
    forever #5 aclk = ~aclk;
  end

  // ==========================================
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  function automatic logic fast_exp(input logic [31:0] c);
    return (c[2:0] != 3'h0) || c[3];
  endfunction

  task automatic test_done();
    $display("Errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      test_done();
    end
  end

  // Core clock phase lengths and flag exclusivity
  always @(posedge aclk) begin
    if (!aresetn) begin
      seen_edge = 0;
      run_len = 0;
    end else if (core_clk !== last_clk) begin
      if (seen_edge && run_len < min_phase) min_phase = run_len;
      if (seen_edge && run_len > max_phase) max_phase = run_len;
      seen_edge = 1;
      run_len = 1;
    end else begin
      run_len++;
    end
    last_clk = core_clk;
    if (aresetn) chk(32'($countones({startup_timer_done_flag, internal_osc_stable_flag,
      secondary_clock_active_flag}) <= 1), 1, "flags");
  end

  // ==========================================
  // Register bus master
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    awvalid <= 1;
    awaddr <= a;
    wvalid <= 1;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 0;
  endtask

  task automatic rdr(input logic [31:0] a);
    @(posedge aclk);
    arvalid <= 1;
    araddr <= a;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 0;
  endtask

  // ==========================================
  // Switch and wait for completion, then judge the pause
  task automatic sw(input logic [31:0] c, input int po, input int pn, input logic [1:0] src);
    int n;
    max_phase = 0;
    wr(`GFCS_CTRL_OFS, c);
    n = 0;
    do begin
      rdr(`GFCS_STAT_OFS);
      n++;
    end while ((rd[3] !== 1'b0 || rd[5:4] !== src) && n < 9000);
    chk(rd[5:3], {src, 1'b0}, "switch done");
    repeat (pn) @(posedge aclk);
    chk(32'(max_phase <= 3 * po + 4 * pn + 24), 1, "pause long");
    chk(32'(max_phase >= 2 * po), 1, "pause short");
    rdr(`GFCS_CTRL_OFS);
    chk(rd, c, "ctrl kept");
  endtask

  task automatic period(input int exp);
    int n, k;
    n = 0;
    for (k = 0; k < 4; k++) begin
      if (k == 2) n = 0;
      while (core_clk !== !k[0] && n < 8000) begin
        @(posedge aclk);
        n++;
      end
    end
    chk(n, exp, "period");
  endtask

  // ==========================================
  // Scenarios
  initial begin
    int i;
    logic [31:0] v;
    void'($urandom(97250));
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    repeat (100) @(posedge aclk);
    rdr(`GFCS_CTRL_OFS);
    chk(rd, 32'h4, "reset ctrl");
    chk(rsp, `GFCS_RESP_OKAY, "read okay");
    chk(primary_osc_enable, 1, "primary on");
    rdr(32'h0000_0008);
    chk(rsp, `GFCS_RESP_SLVERR, "unmapped read");
    chk(rd, 32'h0, "unmapped data");
    wr(32'h0000_1000, 32'h3f);
    chk(rsp, `GFCS_RESP_SLVERR, "unmapped write");
    for (i = 0; i < 2; i++) begin
      wr(`GFCS_CTRL_OFS, i == 0 ? 32'h84 : 32'h104);
      repeat (3) @(posedge aclk);
      chk(slow_rc_enable, 1, "slow rc kept");
    end
    for (i = 0; i < 8; i++) begin
      v = $urandom & 32'h4f;
      wr(`GFCS_CTRL_OFS, v);
      rdr(`GFCS_CTRL_OFS);
      chk(rd, v, "ctrl readback");
      chk(fast_osc_enable, fast_exp(v), "fast enable");
      chk(idle_on_sleep_enable, v[6], "idle copy");
    end
    wr(`GFCS_CTRL_OFS, 32'h0);
    repeat (3) @(posedge aclk);
    chk(fast_osc_enable, 0, "fast off");
    sw(32'h20, 16, 40, 2'h2);
    chk(internal_osc_stable_flag, 0, "no indication");
    period(40);
    sw(32'h0, 40, 16, 2'h0);
    chk({startup_timer_done_flag, internal_osc_stable_flag}, 2'b10, "on primary");
    fast_delay <= 200;
    max_phase = 0;
    wr(`GFCS_CTRL_OFS, 32'h27);
    repeat (100) @(posedge aclk);
    chk(internal_osc_stable_flag, 0, "flag early");
    chk(32'(max_phase <= 9), 1, "clock kept");
    rdr(`GFCS_STAT_OFS);
    chk(rd[5:3], 3'b001, "waiting");
    sw(32'h27, 16, 12, 2'h2);
    chk(internal_osc_stable_flag, 1, "stable");
    chk(32'(min_phase >= 5), 1, "no glitch");
    period(12);
    wr(`GFCS_CTRL_OFS, 32'h25);
    repeat (4) @(posedge aclk);
    chk(internal_osc_stable_flag, 1, "flag kept");
    period(48);
    wr(`GFCS_CTRL_OFS, 32'h28);
    repeat (4) @(posedge aclk);
    chk(internal_osc_stable_flag, 1, "flag kept lfs");
    period(3072);
    wr(`GFCS_CTRL_OFS, 32'h27);
    pri_stall <= 1;
    repeat (20) @(posedge aclk);
    max_phase = 0;
    wr(`GFCS_CTRL_OFS, 32'h07);
    repeat (150) @(posedge aclk);
    chk({startup_timer_done_flag, internal_osc_stable_flag}, 2'b01, "still internal");
    chk(32'(max_phase <= 7), 1, "internal clocks");
    rdr(`GFCS_STAT_OFS);
    chk(rd[5:4], 2'h2, "not switched");
    pri_stall <= 0;
    sw(32'h07, 12, 16, 2'h0);
    chk({startup_timer_done_flag, internal_osc_stable_flag}, 2'b10, "switched");
    sec_on <= 1;
    sw(32'h17, 16, 20, 2'h1);
    chk({startup_timer_done_flag, secondary_clock_active_flag}, 2'b01, "secondary");
    aresetn <= 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    repeat (100) @(posedge aclk);
    rdr(`GFCS_CTRL_OFS);
    chk(rd, 32'h4, "second reset");
    rdr(`GFCS_STAT_OFS);
    chk(rd[5:4], 2'h0, "primary again");
    test_done();
  end
endmodule
